// ==== src/lanpd_defs.svh ====
// Purpose: constants for the negotiation arbiter
// Assumes: 100 MHz sys_clk
// Notes: bit positions follow the management register layout
// Behaviour
// - Exchange only when both sides negotiate
// - Send burst words, not normal pulses
// - Burst word comes from advertisement register
// - Store decoded partner word as partner ability
// - Pick highest common technology by priority
// - Set completion flag and its copy
// - Enable resolved technology, disable others
// - No burst reply: parallel detect, clear capable (a detect fault leaves capable as it was)
// - Set detected technology partner ability bit
// - Parallel detect sets completion, enables technology
// - Normal pulses only mean 10Base-T
// - Scrambled idles mean 100Base-TX without negotiation
// - Burst reply sets partner capable bit
// - No signal sets signal-detect status bit
// - Several indications: no technology, fault bit
// - Restart bit or enable toggle restarts
// - Reset returns arbiter and monitor idle
`ifndef LANPD_DEFS_SVH
`define LANPD_DEFS_SVH
`define LANPD_ABIL_10HD 5
`define LANPD_ABIL_10FD 6
`define LANPD_ABIL_TXHD 7
`define LANPD_ABIL_TXFD 8
`define LANPD_ABIL_T4 9
`define LANPD_WAIT_MS 50
`define LANPD_WAIT_CYC (`LANPD_WAIT_MS * 100000)
`define LANPD_ADV_RST 16'h01e1
`endif

// ==== src/lanpd_pkg.sv ====
// Purpose: types for the negotiation arbiter
// Assumes: nothing
// Notes: technology codes double as enable selectors
package lanpd_pkg;
  // Resolved technology
  typedef enum logic [2:0] {
    TECH_NONE,
    TECH_10HD,
    TECH_10FD,
    TECH_TXHD,
    TECH_TXFD
  } lanpd_tech_t;
  // Arbitration states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEND,
    ST_ACK,
    ST_DONE,
    ST_FAULT
  } lanpd_state_t;
endpackage

// ==== src/lanpd_res_if.sv ====
// Purpose: carries advertisement and partner word to the resolver
// Assumes: single clock
// Notes: combinational result
`timescale 1ns/1ps
`default_nettype none
interface lanpd_res_if;
  logic [15:0] advWord; // Local word
  logic [15:0] lpWord; // Partner word
  lanpd_pkg::lanpd_tech_t tech; // Result
  modport arb (output advWord, output lpWord, input tech);
  modport res (input advWord, input lpWord, output tech);
endinterface
`default_nettype wire

// ==== src/lanpd_resolve.sv ====
// Purpose: priority resolution of common technology
// Assumes: words use the ability field layout
// Notes: T4 is never selected, not supported
`timescale 1ns/1ps
`default_nettype none
`include "lanpd_defs.svh"
module lanpd_resolve (
  lanpd_res_if.res r
);
  logic [15:0] common;
  // ----------------------------------------
  // Priority pick
  // ----------------------------------------
  always_comb begin
    common = r.advWord & r.lpWord;
    if (common[`LANPD_ABIL_TXFD]) begin
      r.tech = lanpd_pkg::TECH_TXFD;
    end else if (common[`LANPD_ABIL_TXHD]) begin
      r.tech = lanpd_pkg::TECH_TXHD;
    end else if (common[`LANPD_ABIL_10FD]) begin
      r.tech = lanpd_pkg::TECH_10FD;
    end else if (common[`LANPD_ABIL_10HD]) begin
      r.tech = lanpd_pkg::TECH_10HD;
    end else begin
      r.tech = lanpd_pkg::TECH_NONE;
    end
  end
endmodule
`default_nettype wire

// ==== src/lanpd_arbiter.sv ====
// Purpose: negotiation arbiter with parallel detection
// Assumes: receive indications are decoded one-cycle or level inputs
// Notes: all outputs registered
`timescale 1ns/1ps
`default_nettype none
`include "lanpd_defs.svh"
module lanpd_arbiter #(
  parameter int WAIT_CYC = `LANPD_WAIT_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic anEnable, // Local negotiation enable
  input wire logic anRestart, // Restart request pulse
  input wire logic [15:0] advWord, // Local advertisement
  input wire logic rxFlp, // Burst received, word valid
  input wire logic [15:0] rxFlpWord, // Decoded partner word
  input wire logic rxNlp, // Normal link pulses seen
  input wire logic rxIdle100, // Scrambled idles seen
  input wire logic rxSignal, // Any energy on receive
  output logic txFlpEn, // Send bursts
  output logic txNlpEn, // Send normal pulses
  output logic [15:0] txWord, // Burst content
  output logic [15:0] lpAbility, // Partner ability
  output logic anComplete, // Completion flag
  output logic anCompleteCopy, // Consolidated copy
  output logic partnerNegotiationCapable, // Partner capable
  output logic parDetFault, // Parallel detect fault
  output logic noSignal, // No signal present
  output logic restartAck, // Restart bit self-clear
  output logic [4:0] techEnable, // One-hot tech enables
  output logic [3:0] progress // Progress status
);
  // ----------------------------------------
  // Internal state
  // ----------------------------------------
  lanpd_pkg::lanpd_state_t state_r; // Arbitration state
  logic [31:0] wait_r; // Response timer
  logic anEnPrev_r; // Enable history
  logic restartReq; // Any restart cause
  logic [1:0] indCount; // Simultaneous indications
  logic timeout; // Response window used up
  lanpd_res_if ri(); // Carrier to the resolver

  // ----------------------------------------
  // Priority resolver
  // ----------------------------------------
  // Compares our advertisement with the stored partner word
  lanpd_resolve u_res (
    .r(ri)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Technology code to one-hot enable, nothing for no technology
  function automatic logic [4:0] techOneHot(lanpd_pkg::lanpd_tech_t t);
    techOneHot = 5'h00;
    if (t != lanpd_pkg::TECH_NONE) begin
      techOneHot[t] = 1'b1; // Enable index equals the code
    end
  endfunction

  // Partner ability word with one field bit set
  function automatic logic [15:0] abilityBit(input int pos);
    abilityBit = 16'h0001 << pos;
  endfunction

  // ----------------------------------------
  // Restart detection
  // ----------------------------------------
  // Request pulse, or enable back high after being low
  always_comb begin
    restartReq = anRestart | (anEnable & ~anEnPrev_r);
  end

  // Parallel-detect indications seen in the same cycle
  always_comb begin
    indCount = 2'({1'b0, rxNlp} + {1'b0, rxIdle100});
  end

  // Response window used up with nothing heard
  always_comb begin
    timeout = (wait_r >= 32'(WAIT_CYC));
  end

  // ----------------------------------------
  // Resolver feed
  // ----------------------------------------
  // Stored partner word, not the live one: the receive word only holds
  // while its valid flag stands, and resolution runs a cycle later
  always_comb begin
    ri.advWord = advWord;
    ri.lpWord = lpAbility;
  end

  // ----------------------------------------
  // Enable history and restart strobe
  // ----------------------------------------
  // Previous enable level, for the toggle restart
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      anEnPrev_r <= 1'b0;
    end else begin
      anEnPrev_r <= anEnable;
    end
  end

  // Self-clear strobe for the restart bit, one cycle after the write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      restartAck <= 1'b0;
    end else begin
      restartAck <= anRestart;
    end
  end

  // ----------------------------------------
  // Arbitration state machine
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= lanpd_pkg::ST_IDLE;
      wait_r <= 32'h0;
      lpAbility <= 16'h0;
      anComplete <= 1'b0;
      anCompleteCopy <= 1'b0;
      partnerNegotiationCapable <= 1'b0;
      parDetFault <= 1'b0;
      techEnable <= 5'h00;
      txFlpEn <= 1'b0;
      txNlpEn <= 1'b0;
      txWord <= `LANPD_ADV_RST;
    end else if (restartReq || !anEnable) begin
      // Restart: straight back to bursting; disabled: back to idle
      state_r <= anEnable ? lanpd_pkg::ST_SEND : lanpd_pkg::ST_IDLE;
      wait_r <= 32'h0;
      anComplete <= 1'b0;
      anCompleteCopy <= 1'b0;
      parDetFault <= 1'b0;
      techEnable <= 5'h00;
      txFlpEn <= anEnable;
      txNlpEn <= ~anEnable;
      txWord <= advWord;
    end else begin
      // Forward through negotiation, one step per cycle at most
      unique case (state_r)
        lanpd_pkg::ST_IDLE: begin
          // Enabled with no restart pending: start bursting
          state_r <= lanpd_pkg::ST_SEND;
          txFlpEn <= 1'b1;
        end
        lanpd_pkg::ST_SEND: begin
          txFlpEn <= 1'b1;
          txNlpEn <= 1'b0;
          txWord <= advWord;
          wait_r <= wait_r + 32'h1;
          if (rxFlp) begin
            lpAbility <= rxFlpWord;
            partnerNegotiationCapable <= 1'b1;
            state_r <= lanpd_pkg::ST_ACK;
          end else if (indCount > 2'd1) begin
            parDetFault <= 1'b1;
            techEnable <= 5'h00;
            state_r <= lanpd_pkg::ST_FAULT;
          end else if (rxNlp || rxIdle100 || timeout) begin
            // No burst in reply: parallel detection
            partnerNegotiationCapable <= 1'b0;
            if (rxNlp) begin
              // Pulse-only partner is 10Base-T half duplex
              lpAbility <= abilityBit(`LANPD_ABIL_10HD);
              techEnable <= techOneHot(lanpd_pkg::TECH_10HD);
              anComplete <= 1'b1;
              anCompleteCopy <= 1'b1;
              txFlpEn <= 1'b0;
              state_r <= lanpd_pkg::ST_DONE;
            end else if (rxIdle100) begin
              // Idle-only partner is 100Base-TX half duplex
              lpAbility <= abilityBit(`LANPD_ABIL_TXHD);
              techEnable <= techOneHot(lanpd_pkg::TECH_TXHD);
              anComplete <= 1'b1;
              anCompleteCopy <= 1'b1;
              txFlpEn <= 1'b0;
              state_r <= lanpd_pkg::ST_DONE;
            end else begin
              wait_r <= 32'h0; // Nothing heard, keep bursting
            end
          end
        end
        lanpd_pkg::ST_ACK: begin
          anComplete <= 1'b1;
          anCompleteCopy <= 1'b1;
          techEnable <= techOneHot(ri.tech);
          txFlpEn <= 1'b0;
          state_r <= lanpd_pkg::ST_DONE;
        end
        lanpd_pkg::ST_DONE: begin
          state_r <= lanpd_pkg::ST_DONE; // Hold until restart
        end
        lanpd_pkg::ST_FAULT: begin
          // Held until restart, disable or reset
          techEnable <= 5'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Signal detect and progress monitor
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      noSignal <= 1'b0;
      progress <= 4'h0;
    end else begin
      noSignal <= ~rxSignal;
      if ({1'b0, state_r} > progress) begin
        progress <= {1'b0, state_r};
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/lanpd_sva.sv ====
// Purpose: port checks for the negotiation arbiter
// Assumes: bound into lanpd_arbiter
// Notes: one clock domain, reset disables all checks but a_rst
`timescale 1ns/1ps
`default_nettype none
module lanpd_sva (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic anEnable,
  input wire logic anRestart,
  input wire logic [15:0] advWord,
  input wire logic rxFlp,
  input wire logic [15:0] rxFlpWord,
  input wire logic rxNlp,
  input wire logic rxIdle100,
  input wire logic txFlpEn,
  input wire logic txNlpEn,
  input wire logic [15:0] txWord,
  input wire logic [15:0] lpAbility,
  input wire logic anComplete,
  input wire logic anCompleteCopy,
  input wire logic partnerNegotiationCapable,
  input wire logic parDetFault,
  input wire logic restartAck,
  input wire logic [4:0] techEnable,
  input wire logic rxSignal,
  input wire logic noSignal,
  input wire logic [3:0] progress
);
  wire logic g = txFlpEn && anEnable && !anRestart; // Negotiating, no restart
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Sampled reset in the antecedent: the release edge itself starts no attempt
  property p_off; !srst && !anEnable |=> !txFlpEn && txNlpEn; endproperty
  a_off: assert property (p_off) else $error("bursts while off");
  property p_word; txFlpEn && $stable(advWord) |-> !txNlpEn && txWord == advWord; endproperty
  a_word: assert property (p_word) else $error("burst word");
  property p_cap; g && rxFlp && !partnerNegotiationCapable
    |=> partnerNegotiationCapable && lpAbility == $past(rxFlpWord); endproperty
  a_cap: assert property (p_cap) else $error("partner word");
  property p_copy; anCompleteCopy == anComplete; endproperty
  a_copy: assert property (p_copy) else $error("completion copy");
  property p_nlp; g && !rxFlp && rxNlp && !rxIdle100 |=> anComplete && techEnable == 5'h02
    && lpAbility[5] && !partnerNegotiationCapable; endproperty
  a_nlp: assert property (p_nlp) else $error("pulse detect");
  property p_idl; g && !rxFlp && !rxNlp && rxIdle100 |=> anComplete && techEnable == 5'h08
    && lpAbility[7] && !partnerNegotiationCapable; endproperty
  a_idl: assert property (p_idl) else $error("idle detect");
  property p_flt; g && !rxFlp && rxNlp && rxIdle100
    |=> parDetFault && techEnable == 5'h00; endproperty
  a_flt: assert property (p_flt) else $error("detect fault");
  property p_sig; !srst |=> noSignal == !$past(rxSignal); endproperty
  a_sig: assert property (p_sig) else $error("signal detect");
  property p_ack; anRestart |=> restartAck; endproperty
  a_ack: assert property (p_ack) else $error("restart ack");
  property p_rst; disable iff (1'b0) srst |=> !anComplete && !txFlpEn && techEnable == 5'h00
    && txWord == 16'h01e1 && progress == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_neg: cover property (anComplete && partnerNegotiationCapable);
  c_pd: cover property (anComplete && !partnerNegotiationCapable);
  c_flt: cover property (parDetFault);
  c_ack: cover property (restartAck);
endmodule
bind lanpd_arbiter lanpd_sva u_lanpd_sva (.*);
`default_nettype wire

// ==== verif/lanpd_partner.sv ====
// Purpose: remote link partner model
// Assumes: mode 1 bursts, 2 pulses, 3 idles, 4 both, 0 silent
// Notes: word line inverted outside its pulse
`timescale 1ns/1ps
`default_nettype none
module lanpd_partner (
  input wire logic sys_clk,
  input wire logic txFlpEn,
  input wire logic [2:0] mode,
  input wire logic [3:0] dly,
  input wire logic [15:0] word,
  output logic rxFlp,
  output logic [15:0] rxFlpWord,
  output logic rxNlp,
  output logic rxIdle100,
  output logic rxSignal
);
  logic [3:0] cnt = 4'h0; // Burst spacing
  // Bursts only in reply to ours, every dly+1 cycles
  always_ff @(posedge sys_clk) begin
    cnt <= (txFlpEn && cnt < dly) ? cnt + 4'h1 : 4'h0;
    rxFlp <= txFlpEn && mode == 3'h1 && cnt == dly;
  end
  assign rxFlpWord = rxFlp ? word : ~word;
  assign rxNlp = mode == 3'h2 || mode == 3'h4;
  assign rxIdle100 = mode == 3'h3 || mode == 3'h4;
  assign rxSignal = mode != 3'h0;
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the negotiation arbiter
// Assumes: partner model on the receive side
// Notes: results checked against a queue of expectations
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0, srst = 1'b1, anEnable = 1'b0, anRestart = 1'b0, seen = 1'b0;
  logic [15:0] advWord = 16'h01e1, word = 16'h0000, rxFlpWord, txWord, lpAbility;
  logic [2:0] mode = 3'h0;
  logic [3:0] dly = 4'h0, progress;
  logic rxFlp, rxNlp, rxIdle100, rxSignal, txFlpEn, txNlpEn, anComplete, anCompleteCopy;
  logic partnerNegotiationCapable, parDetFault, noSignal, restartAck;
  logic [4:0] techEnable;
  logic [38:0] q[$], e;
  logic [22:0] got;
  logic [31:0] s = 32'h00009773;
  int n_fail = 0, check_count = 0;
  always #5 sys_clk = ~sys_clk;
  lanpd_arbiter #(.WAIT_CYC(20)) u_lanpd_arbiter (.*);
  lanpd_partner u_lanpd_partner (.*);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Highest common technology, T4 never chosen
  function automatic logic [4:0] prio(input logic [15:0] c);
    if (c[8]) return 5'h10;
    if (c[7]) return 5'h08;
    if (c[6]) return 5'h04;
    return {3'h0, c[5], 1'b0};
  endfunction
  task automatic final_report;
    n_fail += q.size();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic settle;
    repeat (60) begin
      @(posedge sys_clk);
      if (q.size() == 0) break;
    end
  endtask
  // Expect {mask, tech, capable, fault, ability}
  task automatic run(input logic [2:0] m, input logic [15:0] w, a, input logic [3:0] d);
    e = m == 3'h1 ? {16'hffff, prio(w & a), 2'b10, w} : m == 3'h2 ? {16'h00a0, 5'h02, 18'h00020}
      : m == 3'h3 ? {16'h00a0, 5'h08, 18'h00080} : {16'h0000, 5'h00, 18'h10000};
    @(posedge sys_clk);
    anEnable <= 1'b0;
    mode <= m;
    word <= w;
    advWord <= a;
    dly <= d;
    repeat (3) @(posedge sys_clk);
    anEnable <= 1'b1;
    q.push_back(e);
    settle();
    if (m == 3'h1) begin
      q.push_back(e);
      anRestart <= 1'b1;
      @(posedge sys_clk);
      anRestart <= 1'b0;
      settle();
    end
  endtask
  // Result watcher on each new completion or fault
  always @(posedge sys_clk) begin
    seen <= anComplete | parDetFault;
    if ((anComplete | parDetFault) === 1'b1 && !seen && q.size() > 0) begin
      e = q.pop_front();
      got = {techEnable, partnerNegotiationCapable, parDetFault, lpAbility & e[38:23]};
      check_count++;
      if (got !== e[22:0]) begin
        n_fail++;
        $display("[ERR] %0t got %h exp %h", $time, got, e[22:0]);
      end
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      s = xs(s);
      run(3'h1, s[15:0] | 16'h0020, s[31:16] | 16'h0020, {1'b0, s[6:4]});
    end
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    for (int m = 2; m < 5; m++) run(m[2:0], 16'h0000, 16'h01e1, 4'h0);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire
